/* bench/rfp_mon_model.sv */
// Model of the regulator monitors: internal power good per rail
module rfp_mon_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bench control and monitor outputs
  input  wire logic [3:0] pg_bad,
  output logic      [3:0] rail_pg
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rail_pg <= 4'h0;
    else rail_pg <= ~pg_bad;
  end
endmodule

/* bench/rfp_top_tb_top.sv */
// Self-checking bench for the regulator fault protection block
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module rfp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 2;
  logic        pclk, presetn, psel, penable, pwrite, pu_start, pu_rst_slot, powerup_pg_gate_enable;
  logic        pready, pslverr, pu_hold, pu_abort, pd_request, mcu_reset_out_n, er;
  logic        power_good_pin, irq_out_n;
  logic [11:0] paddr, otp_skip;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  otp_limit, otp_timer, rail_pg, clf, pg_bad, reg_on, prpg, slot_rails;
  logic [3:0]  ov, uv, enp;
  logic [15:0] seed;
  int          failures, tests_run, cyc, pd_cnt, ab_cnt;

  rfp_top #(.TICK_CYC(TK)) rfp_top_inst (
    .pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pu_start(pu_start), .pu_rst_slot(pu_rst_slot),
    .slot_rails(slot_rails), .pu_hold(pu_hold), .pu_abort(pu_abort),
    .pd_request(pd_request), .mcu_reset_out_n(mcu_reset_out_n), .otp_limit(otp_limit),
    .otp_timer(otp_timer), .otp_skip(otp_skip), .powerup_pg_gate_enable(powerup_pg_gate_enable),
    .rail_pg(rail_pg), .current_limit_fault(clf), .raw_ov(ov), .raw_uv(uv),
    .regulator_enable_pin(enp), .reg_on(reg_on), .power_good_pin(power_good_pin),
    .per_rail_power_good_pin(prpg), .irq_out_n(irq_out_n));

  rfp_mon_model rfp_mon_model_inst (
    .pclk(pclk), .presetn(presetn), .pg_bad(pg_bad), .rail_pg(rail_pg));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task end_of_test();
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task tk(input int n);
    repeat (n * TK) @(posedge pclk);
  endtask

  // One APB transfer, waits for pready, then releases
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task pwrup(input logic chk);
    powerup_pg_gate_enable <= chk;
    pu_start <= 1'b1;
    @(posedge pclk);
    pu_start <= 1'b0;
    pu_rst_slot <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (pd_request === 1'b1) pd_cnt++;
    if (pu_abort === 1'b1) ab_cnt++;
    if (cyc == 12000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, pu_start, pu_rst_slot, powerup_pg_gate_enable} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    clf = 4'h0;
    ov = 4'h0;
    uv = 4'h0;
    enp = 4'h1;
    pg_bad = 4'h1;
    slot_rails = 4'h1;
    otp_timer = 4'hf;
    seed = 16'd22183;
    seed = lfsr(seed);
    otp_skip = seed[11:0];
    otp_limit = seed[15:12] | 4'h1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("irq idle", 1'b1, irq_out_n)
    apb(1'b0, 12'h000, 32'h0);
    `CHK("ctrl rst", 32'h0, rv)
    `CHK("ok no err", 1'b0, er)
    apb(1'b0, 12'h004, 32'h0);
    `CHK("keep rst", 32'h0, rv)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    pwrup(1'b1);
    `CHK("pu hold", 1'b1, pu_hold)
    `CHK("mcu held", 1'b0, mcu_reset_out_n)
    tk(210);
    `CHK("abort", 1, ab_cnt)
    pwrup(1'b1);
    tk(100);
    pg_bad <= 4'h0;
    tk(3);
    `CHK("mcu late", 1'b1, mcu_reset_out_n)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("limit load", {otp_limit, 4'h0}, rv[7:0])
    apb(1'b0, 12'h008, 32'h0);
    `CHK("skip load", {20'h0, otp_skip}, rv)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("timer load", 32'hf, rv)
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h00c, 32'h30);
    apb(1'b1, 12'h000, 32'h10f);
    tk(2);
    `CHK("rails on", 4'hf, reg_on)
    clf <= 4'h1;
    tk(95);
    `CHK("cl early", 4'hf, reg_on)
    tk(10);
    `CHK("cl trip", 4'he, reg_on)
    `CHK("irq set", 1'b0, irq_out_n)
    clf <= 4'h0;
    tk(140);
    `CHK("reen early", 4'he, reg_on)
    tk(20);
    `CHK("reen done", 4'hf, reg_on)
    clf <= 4'h2;
    tk(110);
    clf <= 4'h0;
    tk(170);
    `CHK("locked", 4'hd, reg_on)
    apb(1'b1, 12'h000, 32'h10d);
    apb(1'b1, 12'h000, 32'h10f);
    tk(2);
    `CHK("toggle", 4'hf, reg_on)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("count", 8'h32, rv[7:0])
    apb(1'b1, 12'h018, 32'hfff);
    apb(1'b1, 12'h008, 32'h4);
    clf <= 4'h4;
    tk(110);
    `CHK("skip on", 4'hf, reg_on)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("skip count", 8'h32, rv[7:0])
    apb(1'b0, 12'h018, 32'h0);
    `CHK("skip latch", 4'h4, rv[3:0])
    clf <= 4'h0;
    apb(1'b1, 12'h00c, 32'h33);
    clf <= 4'h8;
    tk(110);
    `CHK("limit pd", 1, pd_cnt)
    `CHK("limit off", 4'h0, reg_on)
    clf <= 4'h0;
    pg_bad <= 4'h1;
    tk(110);
    pwrup(1'b0);
    `CHK("no pg gate", 1'b1, mcu_reset_out_n)
    apb(1'b1, 12'h008, 32'h200);
    apb(1'b1, 12'h000, 32'h11f);
    `CHK("pg pin on", 1'b1, power_good_pin)
    uv <= 4'h1;
    tk(25);
    `CHK("pg low", 4'he, prpg)
    `CHK("pg pin low", 1'b0, power_good_pin)
    `CHK("uv early", 4'hf, reg_on)
    tk(10);
    `CHK("uv trip", 4'he, reg_on)
    uv <= 4'h0;
    tk(60);
    `CHK("uv reen", 4'hf, reg_on)
    `CHK("pg back", 1'b1, power_good_pin)
    enp <= 4'h0;
    tk(2);
    `CHK("pin off", 4'he, reg_on)
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    `CHK("timer wr", 32'h0, rv)
    apb(1'b1, 12'h00c, 32'h0);
    apb(1'b1, 12'h004, 32'hfff);
    apb(1'b1, 12'h000, 32'hf);
    clf <= 4'h1;
    ov <= 4'h2;
    tk(150);
    `CHK("timer run", 1, pd_cnt)
    `CHK("ov skip pg", 1'b1, power_good_pin)
    tk(100);
    `CHK("timer pd", 2, pd_cnt)
    end_of_test();
  end
endmodule

/* design/rfp_rail.sv */
// Fault qualification and enable control for one regulator
`include "rfp_cfg.svh"
module rfp_rail
  import rfp_pkg::*;
(
  // Clock and control
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      ce,
  input  wire logic      tick,
  input  wire logic      clr,
  input  wire logic      mon_on,
  input  wire logic      ovuv_on,
  // Configuration and monitors
  input  wire rfp_rcfg_t cfg,
  input  wire logic      en_pin,
  input  wire rfp_flt_t  raw,
  // Results
  output logic           rail_on,
  output rfp_flt_t       det_rise,
  output logic           fault_evt,
  output logic           fault_act,
  output logic           pg_low
);
  logic        cl_q;
  logic [7:0]  clc_q;
  logic [7:0]  pc_q;
  logic [7:0]  wc_q;
  logic [2:0]  detv;
  logic [2:0]  actv;
  logic [2:0]  offv;
  logic [2:0]  detp_q;
  logic [2:0]  actp_q;
  logic        pc_done;
  logic        trip;
  logic        rail_on_q;
  rfp_rstate_t st_q;

  // Current-limit debounce, rising and falling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl_q  <= 1'b0;
      clc_q <= 8'h00;
    end else if (ce) begin
      if (!mon_on || raw.cl == cl_q) begin
        cl_q  <= cl_q & mon_on;
        clc_q <= 8'h00;
      end else if (tick) begin
        if (clc_q == (cl_q ? 8'(`RFP_CL_REL_TK - 1) : 8'(`RFP_CL_QUAL_TK - 1))) begin
          cl_q  <= raw.cl;
          clc_q <= 8'h00;
        end else begin
          clc_q <= clc_q + 8'h01;
        end
      end
    end
  end

  assign detv    = {raw.ov & ovuv_on, raw.uv & ovuv_on, cl_q};
  assign actv    = detv & ~cfg.skip;
  assign offv    = actv & ~cfg.keep;
  assign pc_done = (pc_q == 8'(`RFP_OVUV_TK));
  assign trip    = offv[0] | ((|offv[2:1]) & pc_done);

  // Overvoltage and undervoltage persistence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= 8'h00;
    end else if (ce) begin
      if (!(|offv[2:1])) begin
        pc_q <= 8'h00;
      end else if (tick && !pc_done) begin
        pc_q <= pc_q + 8'h01;
      end
    end
  end

  // Enable state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= RS_RUN;
      wc_q <= 8'h00;
    end else if (ce) begin
      if (clr) begin
        st_q <= RS_RUN;
        wc_q <= 8'h00;
      end else begin
        unique case (st_q)
          RS_RUN: begin
            if (trip) begin
              st_q <= RS_TRIP;
            end
          end
          RS_TRIP: begin
            wc_q <= 8'h00;
            if (!(|actv)) begin
              st_q <= cfg.reen ? RS_WAIT : RS_LOCK;
            end
          end
          RS_WAIT: begin
            if (|actv) begin
              st_q <= RS_TRIP;
            end else if (tick) begin
              if (wc_q == 8'(`RFP_REEN_TK - 1)) begin
                st_q <= RS_RUN;
              end else begin
                wc_q <= wc_q + 8'h01;
              end
            end
          end
          RS_LOCK: begin
            if (!cfg.sw_en) begin
              st_q <= RS_REARM;
            end
          end
          RS_REARM: begin
            if (cfg.sw_en) begin
              st_q <= RS_RUN;
            end
          end
          default: begin
            st_q <= RS_TRIP;
          end
        endcase
      end
    end
  end

  // Output and edge registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rail_on_q <= 1'b0;
      detp_q    <= 3'h0;
      actp_q    <= 3'h0;
    end else if (ce) begin
      rail_on_q <= (st_q == RS_RUN) && (cfg.pin_sel ? en_pin : cfg.sw_en);
      detp_q    <= detv;
      actp_q    <= actv;
    end
  end

  assign rail_on   = rail_on_q;
  assign det_rise  = detv & ~detp_q;
  assign fault_evt = |(actv & ~actp_q);
  assign fault_act = |actv;
  assign pg_low    = |actv[2:1];

  chk_cl_trip_now: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !clr && st_q == RS_RUN && offv[0]) |=> st_q == RS_TRIP)
    else $error("current-limit did not switch the rail off");
  chk_ovuv_hold_on: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !clr && st_q == RS_RUN && !offv[0] && !pc_done) |=> st_q == RS_RUN)
    else $error("rail switched off before the persistence time");
  chk_lock_no_reen: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !clr && st_q == RS_TRIP && actv == 3'h0 && !cfg.reen) |=> st_q == RS_LOCK)
    else $error("rail did not stay locked off");
  chk_reen_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !clr && st_q == RS_WAIT && actv == 3'h0 && tick
     && wc_q == 8'(`RFP_REEN_TK - 1)) |=> st_q == RS_RUN)
    else $error("rail not restored after re-enable wait");
endmodule

/* design/rfp_top.sv */
// Regulator fault protection for four regulators with APB registers
`include "rfp_cfg.svh"
module rfp_top
  import rfp_pkg::*;
#(
  parameter int unsigned TICK_CYC = `RFP_TICK_CYC
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Power-up sequencer
  input  wire logic        pu_start,
  input  wire logic        pu_rst_slot,
  input  wire logic [3:0]  slot_rails,
  output logic             pu_hold,
  output logic             pu_abort,
  output logic             pd_request,
  output logic             mcu_reset_out_n,
  // Fuse defaults
  input  wire logic [3:0]  otp_limit,
  input  wire logic [3:0]  otp_timer,
  input  wire logic [11:0] otp_skip,
  input  wire logic        powerup_pg_gate_enable,
  // Regulator monitors and controls
  input  wire logic [3:0]  rail_pg,
  input  wire logic [3:0]  current_limit_fault,
  input  wire logic [3:0]  raw_ov,
  input  wire logic [3:0]  raw_uv,
  input  wire logic [3:0]  regulator_enable_pin,
  output logic      [3:0]  reg_on,
  output logic             power_good_pin,
  output logic      [3:0]  per_rail_power_good_pin,
  output logic             irq_out_n
);
  logic [11:0] ctrl_q;
  logic [11:0] keep_q;
  logic [11:0] skip_q;
  logic [3:0]  cnt_q;
  logic [3:0]  limit_q;
  logic [3:0]  tcode_q;
  logic [11:0] latch_q;
  logic [11:0] mask_q;
  logic [11:0] tk_q;
  logic        tick;
  logic [17:0] tmr_q;
  logic        tmr_exp_q;
  logic [17:0] tmr_lim;
  logic        tmr_trip;
  logic [7:0]  pw_q;
  logic        pgchk_q;
  rfp_pstate_t pu_q;
  logic        pg_ok;
  logic        abort;
  logic        cnt_trip;
  logic        evt_any;
  logic        fact;
  logic        mon_on;
  logic        ovuv_on;
  logic        wr;
  logic [31:0] rd_d;
  logic [31:0] prdata_q;
  logic [3:0]  reg_on_q;
  logic [3:0]  prpg_q;
  logic        pg_q;
  logic        irq_n_q;
  logic        pu_abort_q;
  logic        pd_req_q;
  logic        mcu_n_q;
  logic [3:0]  rail_on;
  logic [3:0]  evt_v;
  logic [3:0]  act_v;
  logic [3:0]  pgl_v;
  wire  [11:0] set_v;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a[1:0] == 2'b00) && (a <= `RFP_OFF_FMASK);
  endfunction

  function automatic logic [17:0] tmr_ticks(input logic [3:0] code);
    if (code <= `RFP_TMR_TOP) begin
      tmr_ticks = 18'((32'h1 << code) * `RFP_MS_TK);
    end else if (code == `RFP_TMR_LONG) begin
      tmr_ticks = 18'(`RFP_TMR_MAX_MS * `RFP_MS_TK);
    end else begin
      tmr_ticks = 18'h0;
    end
  endfunction

  // Timebase tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk_q <= 12'h000;
    end else if (pce) begin
      tk_q <= tick ? 12'h000 : tk_q + 12'h001;
    end
  end
  assign tick = (tk_q == 12'(TICK_CYC - 1));

  assign mon_on  = (pu_q != PU_OFF);
  assign ovuv_on = (pu_q == PU_ON);

  // Per-regulator protection
  for (genvar i = 0; i < 4; i++) begin : g_rail
    rfp_rcfg_t cfg;
    rfp_flt_t  raw;
    rfp_flt_t  rise;
    assign cfg.keep    = '{ov: keep_q[8+i], uv: keep_q[4+i], cl: keep_q[i]};
    assign cfg.skip    = '{ov: skip_q[8+i], uv: skip_q[4+i], cl: skip_q[i]};
    assign cfg.reen    = ctrl_q[8+i];
    assign cfg.sw_en   = ctrl_q[i];
    assign cfg.pin_sel = ctrl_q[4+i];
    assign raw         = '{ov: raw_ov[i], uv: raw_uv[i], cl: current_limit_fault[i]};
    assign set_v[i]    = rise.cl;
    assign set_v[4+i]  = rise.uv;
    assign set_v[8+i]  = rise.ov;
    rfp_rail u_rail (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (pce),
      .tick      (tick),
      .clr       (pu_start),
      .mon_on    (mon_on),
      .ovuv_on   (ovuv_on),
      .cfg       (cfg),
      .en_pin    (regulator_enable_pin[i]),
      .raw       (raw),
      .rail_on   (rail_on[i]),
      .det_rise  (rise),
      .fault_evt (evt_v[i]),
      .fault_act (act_v[i]),
      .pg_low    (pgl_v[i])
    );
  end

  assign evt_any  = (|evt_v) && mon_on;
  assign fact     = (|act_v) && mon_on;
  assign cnt_trip = evt_any && (cnt_q == limit_q) && (limit_q != 4'h0);
  assign pg_ok    = &(rail_pg | ~slot_rails);
  assign abort    = (pu_q == PU_CHECK) && !pg_ok && tick
                    && (pw_q == 8'(`RFP_PG_WAIT_TK - 1));
  assign wr       = psel && penable && pwrite;

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `RFP_CTRL_RST;
      keep_q <= `RFP_KEEP_RST;
      skip_q <= 12'h000;
      mask_q <= `RFP_MASK_RST;
    end else if (pce) begin
      if (pu_start) begin
        keep_q <= `RFP_KEEP_RST;
        skip_q <= otp_skip;
      end else if (wr && paddr == `RFP_OFF_KEEP) begin
        keep_q <= pwdata[11:0];
      end else if (wr && paddr == `RFP_OFF_SKIP) begin
        skip_q <= pwdata[11:0];
      end
      if (wr && paddr == `RFP_OFF_CTRL) begin
        ctrl_q <= pwdata[11:0];
      end
      if (wr && paddr == `RFP_OFF_FMASK) begin
        mask_q <= pwdata[11:0];
      end
    end
  end

  // Global fault count and limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 4'h0;
      limit_q <= 4'h0;
    end else if (pce) begin
      if (pu_start) begin
        cnt_q   <= 4'h0;
        limit_q <= otp_limit;
      end else begin
        if (evt_any && cnt_q != limit_q) begin
          cnt_q <= cnt_q + 4'h1;
        end else if (wr && paddr == `RFP_OFF_FCOUNT) begin
          cnt_q <= pwdata[3:0];
        end
        if (wr && paddr == `RFP_OFF_FCOUNT) begin
          limit_q <= pwdata[7:4];
        end
      end
    end
  end

  // Fault timer
  assign tmr_lim  = tmr_ticks(tcode_q);
  assign tmr_trip = fact && tick && !tmr_exp_q && (tmr_lim != 18'h0)
                    && (tmr_q == tmr_lim - 18'h1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcode_q   <= 4'h0;
      tmr_q     <= 18'h0;
      tmr_exp_q <= 1'b0;
    end else if (pce) begin
      if (pu_start) begin
        tcode_q <= otp_timer;
      end else if (wr && paddr == `RFP_OFF_FTIMER && pu_q == PU_ON) begin
        tcode_q <= pwdata[3:0];
      end
      if (!fact) begin
        tmr_q     <= 18'h0;
        tmr_exp_q <= 1'b0;
      end else if (tmr_trip) begin
        tmr_exp_q <= 1'b1;
      end else if (tick && !tmr_exp_q) begin
        tmr_q <= tmr_q + 18'h1;
      end
    end
  end

  // Power-up gating and shutdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_q    <= PU_OFF;
      pw_q    <= 8'h00;
      pgchk_q <= 1'b0;
    end else if (pce) begin
      if (pu_q != PU_OFF && (cnt_trip || tmr_trip)) begin
        pu_q <= PU_OFF;
      end else begin
        unique case (pu_q)
          PU_OFF: begin
            if (pu_start) begin
              pu_q    <= PU_SEQ;
              pgchk_q <= powerup_pg_gate_enable;
            end
          end
          PU_SEQ: begin
            pw_q <= 8'h00;
            if (pu_rst_slot) begin
              pu_q <= (!pgchk_q || pg_ok) ? PU_ON : PU_CHECK;
            end
          end
          PU_CHECK: begin
            if (pg_ok) begin
              pu_q <= PU_ON;
            end else if (abort) begin
              pu_q <= PU_OFF;
            end else if (tick) begin
              pw_q <= pw_q + 8'h01;
            end
          end
          PU_ON: begin
            pu_q <= PU_ON;
          end
        endcase
      end
    end
  end

  // Interrupt latches, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 12'h000;
    end else if (pce) begin
      latch_q <= (latch_q & ~((wr && paddr == `RFP_OFF_FLATCH) ? pwdata[11:0] : 12'h000))
                 | set_v;
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_on_q   <= 4'h0;
      prpg_q     <= 4'h0;
      pg_q       <= 1'b0;
      irq_n_q    <= 1'b1;
      pu_abort_q <= 1'b0;
      pd_req_q   <= 1'b0;
      mcu_n_q    <= 1'b0;
    end else if (pce) begin
      reg_on_q   <= rail_on & {4{mon_on}};
      prpg_q     <= reg_on_q & ~pgl_v;
      pg_q       <= ovuv_on && !(|pgl_v);
      irq_n_q    <= !(|(latch_q & ~mask_q));
      pu_abort_q <= abort && !pg_ok;
      pd_req_q   <= (pu_q != PU_OFF) && (cnt_trip || tmr_trip);
      mcu_n_q    <= (pu_q == PU_ON) && !cnt_trip && !tmr_trip;
    end
  end

  // APB read data
  always_comb begin
    rd_d = 32'h0;
    unique case (paddr)
      `RFP_OFF_CTRL:   rd_d = {20'h0, ctrl_q};
      `RFP_OFF_KEEP:   rd_d = {20'h0, keep_q};
      `RFP_OFF_SKIP:   rd_d = {20'h0, skip_q};
      `RFP_OFF_FCOUNT: rd_d = {24'h0, limit_q, cnt_q};
      `RFP_OFF_FTIMER: rd_d = {28'h0, tcode_q};
      `RFP_OFF_STATUS: rd_d = {20'h0, tmr_exp_q, fact, pu_q, 4'h0, reg_on_q};
      `RFP_OFF_FLATCH: rd_d = {20'h0, latch_q};
      `RFP_OFF_FMASK:  rd_d = {20'h0, mask_q};
      default:         rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (pce && psel && !penable) begin
      prdata_q <= rd_d;
    end
  end

  assign prdata                  = prdata_q;
  assign pready                  = 1'b1;
  assign pslverr                 = psel && penable && !addr_hit(paddr);
  assign pu_hold                 = (pu_q == PU_CHECK);
  assign pu_abort                = pu_abort_q;
  assign pd_request              = pd_req_q;
  assign mcu_reset_out_n         = mcu_n_q;
  assign reg_on                  = reg_on_q;
  assign power_good_pin          = pg_q;
  assign per_rail_power_good_pin = prpg_q;
  assign irq_out_n               = irq_n_q;

  chk_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && !pu_start && evt_any && cnt_q != limit_q) |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("fault count did not step");
  chk_cnt_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && evt_any && cnt_q == limit_q && limit_q != 4'h0)
    |=> pd_request && pu_q == PU_OFF)
    else $error("count limit did not power down");
  chk_limit_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && pu_q == PU_ON && evt_any && limit_q == 4'h0 && !tmr_trip) |=> pu_q == PU_ON)
    else $error("zero limit still shut down");
  chk_tmr_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && tmr_trip && pu_q != PU_OFF) |=> pd_request && !mcu_reset_out_n)
    else $error("timer expiry did not power down");
  chk_gate_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && pu_q == PU_SEQ && pu_rst_slot && pgchk_q && !pg_ok && !cnt_trip && !tmr_trip)
    |=> pu_q == PU_CHECK && !mcu_reset_out_n)
    else $error("reset released without power good");
  chk_hold_reset: assert property (@(posedge pclk) disable iff (!presetn)
    pu_q == PU_CHECK |-> !mcu_reset_out_n && pu_hold)
    else $error("reset released during power-good wait");
  chk_abort_off: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && abort && !cnt_trip && !tmr_trip) |=> pu_abort ##1 reg_on == 4'h0)
    else $error("abort did not turn rails off");
  chk_irq_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && (latch_q & ~mask_q) != 12'h000) |=> !irq_out_n)
    else $error("unmasked latch did not assert interrupt");
endmodule

/* shared/rfp_cfg.svh */
// Constants for the regulator fault protection block
`ifndef RFP_CFG_SVH
`define RFP_CFG_SVH
`define RFP_CLK_HZ       20000000
`define RFP_TICK_NS      10000
`define RFP_TICK_CYC     ((`RFP_TICK_NS * (`RFP_CLK_HZ / 1000000)) / 1000)
`define RFP_CL_QUAL_US   1000
`define RFP_CL_REL_US    1000
`define RFP_OVUV_PER_US  300
`define RFP_REEN_US      500
`define RFP_PG_WAIT_US   2000
`define RFP_MS_US        1000
`define RFP_CL_QUAL_TK   ((`RFP_CL_QUAL_US * 1000 + `RFP_TICK_NS - 1) / `RFP_TICK_NS)
`define RFP_CL_REL_TK    ((`RFP_CL_REL_US * 1000) / `RFP_TICK_NS)
`define RFP_OVUV_TK      ((`RFP_OVUV_PER_US * 1000 + `RFP_TICK_NS - 1) / `RFP_TICK_NS)
`define RFP_REEN_TK      ((`RFP_REEN_US * 1000 + `RFP_TICK_NS - 1) / `RFP_TICK_NS)
`define RFP_PG_WAIT_TK   ((`RFP_PG_WAIT_US * 1000) / `RFP_TICK_NS)
`define RFP_MS_TK        ((`RFP_MS_US * 1000) / `RFP_TICK_NS)
`define RFP_TMR_MAX_MS   2056
`define RFP_TMR_TOP      4'ha
`define RFP_TMR_LONG     4'hb
`define RFP_OFF_CTRL     12'h000
`define RFP_OFF_KEEP     12'h004
`define RFP_OFF_SKIP     12'h008
`define RFP_OFF_FCOUNT   12'h00c
`define RFP_OFF_FTIMER   12'h010
`define RFP_OFF_STATUS   12'h014
`define RFP_OFF_FLATCH   12'h018
`define RFP_OFF_FMASK    12'h01c
`define RFP_CTRL_RST     12'h000
`define RFP_KEEP_RST     12'h000
`define RFP_MASK_RST     12'h000
`endif

/* shared/rfp_pkg.sv */
// Types for the regulator fault protection block
package rfp_pkg;
  typedef struct packed {
    logic ov;
    logic uv;
    logic cl;
  } rfp_flt_t;

  typedef struct packed {
    rfp_flt_t keep;
    rfp_flt_t skip;
    logic     reen;
    logic     sw_en;
    logic     pin_sel;
  } rfp_rcfg_t;

  typedef enum logic [2:0] {
    RS_RUN   = 3'b000,
    RS_TRIP  = 3'b001,
    RS_WAIT  = 3'b010,
    RS_LOCK  = 3'b011,
    RS_REARM = 3'b100
  } rfp_rstate_t;

  typedef enum logic [1:0] {
    PU_OFF   = 2'b00,
    PU_SEQ   = 2'b01,
    PU_CHECK = 2'b10,
    PU_ON    = 2'b11
  } rfp_pstate_t;
endpackage
